//--- core/dmm_pkg.sv
// Purpose: shared constants and types of the data memory map block
// Assumes: byte-wide internal and external-space memories, 256 bytes each
// Notes: apb offsets are byte addresses of aligned 32-bit words
package dmm_pkg;
  // internal data space landmarks
  localparam logic [7:0] DMM_WREG_TOP = 8'h1f; // last working-register byte
  localparam logic [7:0] DMM_BIT_BASE = 8'h20; // first bit-addressable byte
  localparam logic [7:0] DMM_BIT_TOP = 8'h2f; // last bit-addressable byte
  localparam logic [7:0] DMM_LOWER_TOP = 8'h7f; // top of directly reachable ram
  localparam logic [7:0] DMM_UID_BASE = 8'hfc; // first of the four identifier bytes
  localparam logic [7:0] DMM_SP_RESET = 8'h07; // stack pointer after reset
  // program status word fields
  localparam int DMM_BANK_LOW_POS = 3; // bank_select_low
  localparam int DMM_BANK_HIGH_POS = 4; // bank_select_high
  localparam logic [7:0] DMM_PSW_RESET = 8'h00;
  // configuration word fields
  localparam int DMM_CFG_FSWE_POS = 0; // flash_store_write_enable
  localparam int DMM_CFG_UIDI_POS = 1; // identifier in internal ram
  localparam int DMM_CFG_UIDX_POS = 2; // identifier in external-space ram
  localparam logic [7:0] DMM_CFG_RESET = 8'h00;
  // apb register offsets
  localparam logic [11:0] DMM_CFG_OFS = 12'h000;
  localparam logic [11:0] DMM_PSW_OFS = 12'h004;
  localparam logic [11:0] DMM_SP_OFS = 12'h008;
  localparam logic [11:0] DMM_UID_OFS = 12'h00c;
  // access kinds issued by the execution logic
  typedef enum logic [2:0] {
    DMM_OP_DIRECT, // direct byte address
    DMM_OP_INDIRECT, // @working_reg_zero / @working_reg_one
    DMM_OP_WREG, // working register n of active bank
    DMM_OP_BIT, // single bit by bit address
    DMM_OP_PUSH, // stack push
    DMM_OP_POP, // stack pop
    DMM_OP_XDPTR, // external_move_instruction via data_pointer_pair
    DMM_OP_XRI // external_move_instruction via working register
  } dmm_op_t;
endpackage

//--- core/dmm_byte_ram.sv
// Purpose: byte ram with one masked write port and two asynchronous read ports
// Assumes: writes on the rising edge of pclk
// Notes: contents are not reset, as in real sram
`timescale 1ns/1ps
module dmm_byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  input wire logic [AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);
  // storage array
  logic [7:0] mem [DEPTH];

  // the decode assumes a full power-of-two array
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("dmm_byte_ram: DEPTH must equal 2**AW");
  end

  // async reads keep pointer fetch and data access in one cycle
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

  // masked write merges only the selected bits
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
  end
endmodule

//--- core/dmm_data_memory_map.sv
// Purpose: data memory map of the core: banks, bit space, stack, external-space ram
// Assumes: execution logic on pclk issues one access per cycle, answered next cycle
// Notes: configuration, status word and stack pointer reached over apb
//
// What this block does
// - indirect above 0x7F reaches upper ram
// - direct above 0x7F reaches special function space
// - 0x00-0x1F form four eight-register banks
// - status word bank bits pick one bank
// - indirect pointer from active bank register 0/1
// - bytes 0x20-0x2F also hold 128 bits
// - bit address maps to byte 0x20+a/8
// - operand type alone selects bit or byte
// - push writes pointer plus one, then increments
// - reset loads stack pointer with 0x07
// - stack may span all internal memory
// - 256 external-space bytes via both forms
// - upper external address byte is ignored; redirected flash writes keep it in flash_addr
// - external moves target on-chip ram by default
// - identifier option in top internal bytes
// - identifier option in top external bytes
// - flash write enable redirects external writes
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dmm_data_memory_map
  import dmm_pkg::*;
#(
  parameter logic [31:0] UNIT_ID = 32'h5a3c_1e07 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // access port from execution logic
  input wire logic core_req,
  input wire dmm_op_t core_op,
  input wire logic core_we,
  input wire logic [15:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic core_bit_wdata,
  output logic core_ack,
  output logic [7:0] core_rdata,
  // forwarded special function space access
  output logic sfr_req,
  output logic sfr_we,
  output logic sfr_bit,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  // redirected flash byte write
  output logic flash_wr,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  // state views
  output logic [7:0] stack_pointer_out,
  output logic [1:0] active_bank
);
  // software-visible state
  logic [7:0] config_word; // enables and identifier placement
  logic [7:0] program_status_word; // holds bank select bits
  logic [7:0] stack_pointer_reg; // last occupied stack byte
  logic started; // low only in the first cycle after reset

  // ram port wires
  logic [7:0] iram_rdata;
  logic [7:0] iram_ptr;
  logic [7:0] external_space_ram_rdata;
  // the external-space ram needs only one read port; the second stays open

  // decoded controls
  wire fswe = config_word[DMM_CFG_FSWE_POS];
  wire uid_in_iram = config_word[DMM_CFG_UIDI_POS];
  wire uid_in_external_space_ram = config_word[DMM_CFG_UIDX_POS];
  wire [1:0] bank = {program_status_word[DMM_BANK_HIGH_POS], program_status_word[DMM_BANK_LOW_POS]};

  wire [7:0] ptr_addr = {3'b000, bank, 2'b00, core_addr[0]};

  // operation classes
  wire op_direct = core_op == DMM_OP_DIRECT;
  wire op_ind = core_op == DMM_OP_INDIRECT;
  wire op_wreg = core_op == DMM_OP_WREG;
  wire op_bit = core_op == DMM_OP_BIT;
  wire op_push = core_op == DMM_OP_PUSH;
  wire op_pop = core_op == DMM_OP_POP;
  wire op_xdptr = core_op == DMM_OP_XDPTR;
  wire op_xri = core_op == DMM_OP_XRI;
  wire op_x = op_xdptr | op_xri;

  // direct and bit addresses with bit 7 set leave the ram
  wire to_sfr = (op_direct | op_bit) & core_addr[7];

  // bit address to byte and bit position
  wire [7:0] bit_byte = DMM_BIT_BASE + {4'h0, core_addr[6:3]};
  wire [7:0] bit_mask = 8'h01 << core_addr[2:0];

  // stack neighbours; 8-bit wrap lets the stack use all 256 bytes
  wire [7:0] sp_inc = stack_pointer_reg + 8'h01;
  wire [7:0] sp_dec = stack_pointer_reg - 8'h01;

  // internal address select
  // indirect uses the pointer value over the full 256 bytes
  // working register n of bank b sits at 8*b+n
  // push goes to pointer plus one
  wire [7:0] iram_addr = op_ind ? iram_ptr :
                         op_wreg ? {3'b000, bank, core_addr[2:0]} :
                         op_bit ? bit_byte :
                         op_push ? sp_inc :
                         op_pop ? stack_pointer_reg :
                         core_addr[7:0];

  // upper byte of the data_pointer_pair is ignored
  wire [7:0] external_space_ram_addr = op_xri ? iram_ptr : core_addr[7:0];

  // identifier windows replace storage when enabled
  // top four internal bytes
  wire iram_uid_hit = uid_in_iram & (iram_addr >= DMM_UID_BASE);
  wire external_space_ram_uid_hit = uid_in_external_space_ram & (external_space_ram_addr >= DMM_UID_BASE);
  wire [31:0] uid_shift_i = UNIT_ID >> {iram_addr[1:0], 3'b000};
  wire [31:0] uid_shift_x = UNIT_ID >> {external_space_ram_addr[1:0], 3'b000};
  wire [7:0] iram_byte = iram_uid_hit ? uid_shift_i[7:0] : iram_rdata;
  wire [7:0] external_space_ram_byte = external_space_ram_uid_hit ? uid_shift_x[7:0] : external_space_ram_rdata;

  // internal write enable; identifier bytes are read-only
  wire iram_op = ~op_x & ~to_sfr;
  wire iram_we = core_req & iram_op & (core_we | op_push) & ~op_pop & ~iram_uid_hit;
  // only a bit operand narrows the write
  wire [7:0] iram_wmask = op_bit ? bit_mask : 8'hff;
  wire [7:0] iram_wdata = op_bit ? {8{core_bit_wdata}} : core_wdata;

  // external writes stay on chip unless flash writes are enabled
  wire external_space_ram_we = core_req & op_x & core_we & ~fswe & ~external_space_ram_uid_hit;
  wire flash_go = core_req & op_x & core_we & fswe;

  // bit read returns the selected bit of the byte
  wire [2:0] bit_pos = core_addr[2:0];
  wire [7:0] rd_bit = {7'h00, iram_byte[bit_pos]};
  wire [7:0] next_core_rdata = op_x ? external_space_ram_byte : op_bit ? rd_bit : iram_byte;

  // internal ram: port a data, port b pointer register
  dmm_byte_ram #(.DEPTH(256), .AW(8)) u_iram (
    .pclk(pclk),
    .we(iram_we),
    .waddr(iram_addr),
    .wdata(iram_wdata),
    .wmask(iram_wmask),
    .raddr_a(iram_addr),
    .rdata_a(iram_rdata),
    .raddr_b(ptr_addr),
    .rdata_b(iram_ptr)
  );

  // on-chip external-space ram for both move forms
  dmm_byte_ram #(.DEPTH(256), .AW(8)) u_external_space_ram (
    .pclk(pclk),
    .we(external_space_ram_we),
    .waddr(external_space_ram_addr),
    .wdata(core_wdata),
    .wmask(8'hff),
    .raddr_a(external_space_ram_addr),
    .rdata_a(external_space_ram_rdata),
    .raddr_b(8'h00),
    .rdata_b()
  );

  // apb decode; zero-wait-state would need a combinational pready
  wire apb_setup_done = psel & penable & ~pready;
  wire apb_fire = psel & penable & pready;
  wire hit_cfg = paddr == DMM_CFG_OFS;
  wire hit_psw = paddr == DMM_PSW_OFS;
  wire hit_sp = paddr == DMM_SP_OFS;
  wire hit_uid = paddr == DMM_UID_OFS;
  wire hit_any = hit_cfg | hit_psw | hit_sp | hit_uid;
  wire [31:0] next_prdata = hit_cfg ? {24'h000000, config_word} :
                            hit_psw ? {24'h000000, program_status_word} :
                            hit_sp ? {24'h000000, stack_pointer_reg} :
                            hit_uid ? UNIT_ID : 32'h00000000;
  wire apb_wr = apb_fire & pwrite;

  // stack movement wins over a software write in the same cycle
  wire push_go = core_req & op_push;
  wire pop_go = core_req & op_pop;
  wire [7:0] next_sp = push_go ? sp_inc :
                       pop_go ? sp_dec :
                       (apb_wr & hit_sp) ? pwdata[7:0] : stack_pointer_reg;

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup_done;
      prdata <= apb_setup_done ? next_prdata : prdata;
      pslverr <= apb_setup_done & ~hit_any;
    end
  end

  // software registers, written at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_word <= DMM_CFG_RESET;
      program_status_word <= DMM_PSW_RESET;
    end else begin
      if (apb_wr & hit_cfg) begin
        config_word <= pwdata[7:0];
      end
      // bank select comes from the status word
      if (apb_wr & hit_psw) begin
        program_status_word <= pwdata[7:0];
      end
    end
  end

  // pointer wraps freely over the whole space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer_reg <= DMM_SP_RESET;
      started <= 1'b0;
    end else begin
      stack_pointer_reg <= next_sp;
      started <= 1'b1;
    end
  end

  // answers to the execution logic, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      core_rdata <= 8'h00;
      sfr_req <= 1'b0;
      sfr_we <= 1'b0;
      sfr_bit <= 1'b0;
      sfr_addr <= 8'h00;
      sfr_wdata <= 8'h00;
    end else begin
      core_ack <= core_req;
      core_rdata <= core_req ? next_core_rdata : core_rdata;
      sfr_req <= core_req & to_sfr;
      sfr_we <= core_req & to_sfr & core_we;
      sfr_bit <= op_bit;
      sfr_addr <= core_addr[7:0];
      sfr_wdata <= op_bit ? {7'h00, core_bit_wdata} : core_wdata;
    end
  end

  // flash byte write pulse carries the full 16-bit address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wr <= 1'b0;
      flash_addr <= 16'h0000;
      flash_wdata <= 8'h00;
    end else begin
      flash_wr <= flash_go;
      flash_addr <= op_xri ? {8'h00, iram_ptr} : core_addr;
      flash_wdata <= core_wdata;
    end
  end

  // state views straight from flops
  assign stack_pointer_out = stack_pointer_reg;
  assign active_bank = bank;

  // checks
  a_sp_after_reset: assert property (
    @(posedge pclk) disable iff (!presetn) !started |-> stack_pointer_reg == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  a_push_increments: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_PUSH
      |-> iram_addr == stack_pointer_reg + 8'h01 ##1 stack_pointer_reg == $past(stack_pointer_reg) + 8'h01)
    else $error("push did not target and advance pointer");
  a_pop_decrements: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_POP
      |-> !iram_we ##1 stack_pointer_reg == $past(stack_pointer_reg) - 8'h01)
    else $error("pop did not retreat pointer");
  a_indirect_ram: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_INDIRECT |=> core_ack && !sfr_req)
    else $error("indirect access left the ram");
  a_direct_sfr: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_DIRECT && core_addr[7]
      |-> !iram_we ##1 sfr_req && sfr_addr == $past(core_addr[7:0]))
    else $error("direct upper access not forwarded");
  a_bank_address: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_WREG
      |-> iram_addr <= DMM_WREG_TOP && iram_addr[4:3] == active_bank)
    else $error("working register outside active bank");
  a_pointer_source: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_INDIRECT
      |-> ptr_addr[7:1] == {3'b000, active_bank, 2'b00})
    else $error("pointer not from active bank");
  a_bit_map: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_BIT && !core_addr[7]
      |-> iram_addr >= DMM_BIT_BASE && iram_addr <= DMM_BIT_TOP && $onehot(iram_wmask))
    else $error("bit address mapped wrongly");
  a_external_space_ram_alias: assert property (
    @(posedge pclk) disable iff (!presetn) core_req && core_op == DMM_OP_XDPTR |-> external_space_ram_addr == core_addr[7:0])
    else $error("upper external address byte used");
  a_flash_redirect: assert property (
    @(posedge pclk) disable iff (!presetn) flash_go |-> !external_space_ram_we ##1 flash_wr && flash_wdata == $past(core_wdata))
    else $error("write not redirected to flash");
  a_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn) psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  c_push: cover property (@(posedge pclk) disable iff (!presetn) push_go);
  c_push_pop: cover property (@(posedge pclk) disable iff (!presetn) push_go ##1 pop_go);
  c_bit_write: cover property (@(posedge pclk) disable iff (!presetn) iram_we && op_bit);
  c_flash: cover property (@(posedge pclk) disable iff (!presetn) flash_wr);
endmodule

//--- tb/dmm_core_model.sv
// Purpose: stand-in for the execution logic that issues data memory accesses
// Assumes: one access at a time, taken at the edge after it is raised
// Notes: released address and data lines show the inverse of the last value, so stale data never matches
`timescale 1ns/1ps
module dmm_core_model
  import dmm_pkg::*;
(
  input wire logic pclk,
  output logic core_req,
  output dmm_op_t core_op,
  output logic core_we,
  output logic [15:0] core_addr,
  output logic [7:0] core_wdata,
  output logic core_bit_wdata,
  input wire logic core_ack,
  input wire logic [7:0] core_rdata
);
  // idle values at time zero
  initial begin
    core_req = 1'b0;
    core_op = DMM_OP_DIRECT;
    core_we = 1'b0;
    core_addr = 16'h0000;
    core_wdata = 8'h00;
    core_bit_wdata = 1'b0;
  end
  // one access: raise after an edge, drop after the taking edge, read the answer in the ack cycle
  task automatic acc(input dmm_op_t op, input logic we, input logic [15:0] a, input logic [7:0] d,
                     input logic b, output logic [7:0] rd);
    @(posedge pclk);
    core_req <= 1'b1;
    core_op <= op;
    core_we <= we;
    core_addr <= a;
    core_wdata <= d;
    core_bit_wdata <= b;
    @(posedge pclk);
    // released lines carry garbage, not the last value
    core_req <= 1'b0;
    core_we <= 1'b0;
    core_addr <= ~a;
    core_wdata <= ~d;
    core_bit_wdata <= ~b;
    #1;
    rd = core_rdata;
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the data memory map block
// Assumes: apb answers with one wait state, core accesses answered one cycle later
// Notes: memory is not reset, so every byte read back is written first
`timescale 1ns/1ps
module tb_top;
  import dmm_pkg::*;
  localparam logic [31:0] UID_VAL = 32'h3c5a_0f61; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite; // apb master side
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r32;
  logic pready, pslverr, e;
  logic core_req, core_we, core_bit_wdata, core_ack; // execution side
  dmm_op_t core_op;
  logic [15:0] core_addr, flash_addr;
  logic [7:0] core_wdata, core_rdata, r8;
  logic sfr_req, sfr_we, sfr_bit, flash_wr;
  logic [7:0] sfr_addr, sfr_wdata, flash_wdata, stack_pointer_out;
  logic [1:0] active_bank;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int b;
  dmm_data_memory_map #(.UNIT_ID(UID_VAL)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .core_op(core_op), .core_we(core_we), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_bit_wdata(core_bit_wdata), .core_ack(core_ack), .core_rdata(core_rdata),
    .sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_bit(sfr_bit), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .flash_wr(flash_wr), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .stack_pointer_out(stack_pointer_out), .active_bank(active_bank));
  dmm_core_model mdl (.pclk(pclk), .core_req(core_req), .core_op(core_op), .core_we(core_we),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_bit_wdata(core_bit_wdata),
    .core_ack(core_ack), .core_rdata(core_rdata));
  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // four-state compare, so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb transfer: setup, access, hold until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    rd = 32'hx;
    err = 1'bx;
    // wait for the answer however long it takes; only the hang guard ends this
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the completing edge settle before anyone looks at register views
    #1;
  endtask
  // core access through the partner, ack must stand in the answer cycle
  task automatic cx(input dmm_op_t op, input logic we, input logic [15:0] a, input logic [7:0] d,
                    input logic bw, output logic [7:0] rd);
    mdl.acc(op, we, a, d, bw, rd);
    chk("core_ack", {31'h0, core_ack}, 32'h1);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    chk("sp_in_reset", stack_pointer_out, 8'h07);
    presetn <= 1'b1;
    apb(1'b0, DMM_SP_OFS, 32'h0, r32, e);
    chk("sp_reg", r32, 32'h7);
    // unmapped offset is refused with an error and reads zero
    apb(1'b0, 12'h010, 32'h0, r32, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", r32, 32'h0);
    // fill register 2+b of every bank
    for (b = 0; b < 4; b++) begin
      apb(1'b1, DMM_PSW_OFS, 32'(b) << 3, r32, e);
      chk("active_bank", {30'h0, active_bank}, 32'(b));
      cx(DMM_OP_WREG, 1'b1, 16'(b + 2), 8'ha0 + 8'(b), 1'b0, r8);
    end
    for (b = 0; b < 4; b++) begin
      cx(DMM_OP_DIRECT, 1'b0, 16'(9 * b + 2), 8'h00, 1'b0, r8);
      chk("bank_byte", r8, 8'ha0 + 8'(b));
    end
    cx(DMM_OP_WREG, 1'b0, 16'h0005, 8'h00, 1'b0, r8);
    chk("wreg_bank3", r8, 8'ha3);
    // pointers in bank 2, upper ram versus special function space
    apb(1'b1, DMM_PSW_OFS, 32'h10, r32, e);
    cx(DMM_OP_WREG, 1'b1, 16'h0000, 8'h90, 1'b0, r8);
    cx(DMM_OP_WREG, 1'b1, 16'h0001, 8'h31, 1'b0, r8);
    cx(DMM_OP_INDIRECT, 1'b1, 16'h0000, 8'h5c, 1'b0, r8);
    cx(DMM_OP_INDIRECT, 1'b1, 16'h0001, 8'h6d, 1'b0, r8);
    cx(DMM_OP_DIRECT, 1'b0, 16'h0031, 8'h00, 1'b0, r8);
    chk("ptr_reg1", r8, 8'h6d);
    cx(DMM_OP_DIRECT, 1'b0, 16'h0090, 8'h00, 1'b0, r8);
    chk("direct_sfr_req", {31'h0, sfr_req}, 32'h1);
    chk("direct_sfr_addr", sfr_addr, 8'h90);
    chk("direct_sfr_rd", {31'h0, sfr_we}, 32'h0);
    cx(DMM_OP_BIT, 1'b1, 16'h0085, 8'h00, 1'b1, r8);
    chk("bit_sfr_req", {31'h0, sfr_req}, 32'h1);
    chk("bit_sfr_we", {31'h0, sfr_we}, 32'h1);
    chk("bit_sfr_flag", {31'h0, sfr_bit}, 32'h1);
    chk("bit_sfr_addr", sfr_addr, 8'h85);
    chk("bit_sfr_wdata", sfr_wdata, 8'h01);
    cx(DMM_OP_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b0, r8);
    chk("upper_ram", r8, 8'h5c);
    chk("upper_no_sfr", {31'h0, sfr_req}, 32'h0);
    cx(DMM_OP_DIRECT, 1'b1, 16'h002f, 8'h00, 1'b0, r8);
    cx(DMM_OP_BIT, 1'b1, 16'h007f, 8'h00, 1'b1, r8);
    cx(DMM_OP_DIRECT, 1'b0, 16'h002f, 8'h00, 1'b0, r8);
    chk("bit_7f", r8, 8'h80);
    cx(DMM_OP_DIRECT, 1'b1, 16'h0022, 8'h08, 1'b0, r8);
    cx(DMM_OP_BIT, 1'b0, 16'h0013, 8'h00, 1'b0, r8);
    chk("bit_13", r8, 8'h01);
    // stack from reset pointer and near the top
    cx(DMM_OP_PUSH, 1'b1, 16'h0000, 8'h11, 1'b0, r8);
    chk("sp_push", stack_pointer_out, 8'h08);
    cx(DMM_OP_DIRECT, 1'b0, 16'h0008, 8'h00, 1'b0, r8);
    chk("first_push", r8, 8'h11);
    cx(DMM_OP_PUSH, 1'b1, 16'h0000, 8'h22, 1'b0, r8);
    cx(DMM_OP_POP, 1'b0, 16'h0000, 8'h00, 1'b0, r8);
    chk("pop_data", r8, 8'h22);
    chk("sp_pop", stack_pointer_out, 8'h08);
    apb(1'b1, DMM_SP_OFS, 32'hfe, r32, e);
    cx(DMM_OP_PUSH, 1'b1, 16'h0000, 8'h44, 1'b0, r8);
    chk("sp_top", stack_pointer_out, 8'hff);
    cx(DMM_OP_POP, 1'b0, 16'h0000, 8'h00, 1'b0, r8);
    chk("pop_top", r8, 8'h44);
    // external-space ram by both forms, upper byte ignored
    cx(DMM_OP_XDPTR, 1'b1, 16'h0345, 8'h77, 1'b0, r8);
    chk("no_flash_default", {31'h0, flash_wr}, 32'h0);
    cx(DMM_OP_WREG, 1'b1, 16'h0001, 8'h45, 1'b0, r8);
    cx(DMM_OP_XRI, 1'b0, 16'h0001, 8'h00, 1'b0, r8);
    chk("xri_read", r8, 8'h77);
    cx(DMM_OP_XDPTR, 1'b0, 16'hff45, 8'h00, 1'b0, r8);
    chk("xdptr_alias", r8, 8'h77);
    // flash redirect while the write enable is set
    apb(1'b1, DMM_CFG_OFS, 32'h1, r32, e);
    cx(DMM_OP_XDPTR, 1'b1, 16'h1234, 8'h99, 1'b0, r8);
    chk("flash_wr", {31'h0, flash_wr}, 32'h1);
    chk("flash_addr", flash_addr, 32'h1234);
    chk("flash_data", flash_wdata, 8'h99);
    apb(1'b1, DMM_CFG_OFS, 32'h2, r32, e);
    cx(DMM_OP_WREG, 1'b1, 16'h0000, 8'hfd, 1'b0, r8);
    cx(DMM_OP_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b0, r8);
    chk("uid_internal", r8, UID_VAL[15:8]);
    apb(1'b0, DMM_UID_OFS, 32'h0, r32, e);
    chk("uid_reg", r32, UID_VAL);
    apb(1'b1, DMM_CFG_OFS, 32'h4, r32, e);
    cx(DMM_OP_XDPTR, 1'b0, 16'h00ff, 8'h00, 1'b0, r8);
    chk("uid_external", r8, UID_VAL[31:24]);
    report_and_stop();
  end
endmodule
